//--- hdl/rtusd_pkg.sv
// Package for the slave query interpreter: codes, limits and stream structs
package rtusd_pkg;
  localparam logic [7:0] FC_RD_OUT = 8'h01;
  localparam logic [7:0] FC_RD_IN = 8'h02;
  localparam logic [7:0] FC_RD_REG = 8'h03;
  localparam logic [7:0] FC_RD_ANA = 8'h04;
  localparam logic [7:0] FC_FORCE = 8'h05;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] FORCE_OFF = 8'h00;
  localparam logic [7:0] FORCE_ON = 8'hff;
  localparam logic [15:0] MIN_WORDS = 16'h0001;
  localparam logic [15:0] MAX_WORDS = 16'h007d;
  localparam logic [15:0] MAX_POINTS = 16'h0800;
  localparam int QRY_LEN = 6;
  // Highest point or register numbers of the attached tables
  localparam logic [15:0] HI_OUT_DEF = 16'h0100;
  localparam logic [15:0] HI_IN_DEF = 16'h0100;
  localparam logic [15:0] HI_REG_DEF = 16'h0400;
  localparam logic [15:0] HI_ANA_DEF = 16'h0040;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } rtusd_byte_type;

  typedef struct packed {
    logic req;
    logic bits;
    logic [15:0] index;
  } rtusd_rd_type;

  typedef struct packed {
    logic en;
    logic [15:0] index;
    logic value;
  } rtusd_force_type;

  typedef enum logic [2:0] {
    S_RX, S_CHECK, S_HDR, S_FETCH, S_WAIT, S_SEND, S_ECHO
  } rtusd_state_type;
endpackage

//--- hdl/rtusd_decoder.sv
// Slave query interpreter for read-table, read-register and force-output queries
//
// Summary of operation
// - Read queries addressed to station zero are not broadcasts and are dropped.
// - Code 01 reads output points; start field is first point minus one.
// - Two-byte query fields arrive high byte first, then low byte.
// - Point byte count is data bytes after it; 256 is sent as zero.
// - Eight points per byte, point start+1 in bit zero, filling upward.
// - Unused upper bits of the last point byte are sent as zero.
// - Code 02 reads input points like code 01, limited by highest input.
// - Register byte count is twice the register count, 2 to 250.
// - Registers go out ascending from start+1, high byte then low byte.
// - Code 4 reads analog inputs like register reads, limited by highest analog input.
// - Force output to address zero is executed by all, with no response.
// - Code 05 point field is target minus one, below highest output.
// - Force data is 00 for off or ff for on; second byte zero.
// - Addressed force query is answered by echoing the query unchanged.
// - Check bytes are framed outside this block, low byte before high.
`timescale 1ns/1ps
`default_nettype none
module rtusd_decoder (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] station_i,
  input wire logic [15:0] hi_out_i,
  input wire logic [15:0] hi_in_i,
  input wire logic [15:0] hi_reg_i,
  input wire logic [15:0] hi_ana_i,
  input wire rtusd_pkg::rtusd_byte_type rx_i,
  input wire logic tx_ready_i,
  output rtusd_pkg::rtusd_byte_type tx_o,
  output rtusd_pkg::rtusd_rd_type rd_o,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  output rtusd_pkg::rtusd_force_type force_o,
  output logic drop_o
);
  import rtusd_pkg::*;

  typedef struct packed {
    rtusd_state_type st;
    logic [7:0] q0, q1, q2, q3, q4, q5;
    logic [2:0] cnt;
    logic [15:0] idx;
    logic [15:0] left;
    logic [8:0] bytes_left;
    logic [7:0] hdr_pos;
    logic [7:0] acc;
    logic [3:0] bitn;
    logic lo_pending;
    logic [7:0] lo_byte;
    rtusd_byte_type tx;
    rtusd_rd_type rd;
    rtusd_force_type frc;
    logic drop;
  } rtusd_state_all_type;

  rtusd_state_all_type s_q, s_d;

  function automatic logic is_bits(input logic [7:0] fc);
    is_bits = (fc == FC_RD_OUT) || (fc == FC_RD_IN);
  endfunction

  function automatic logic is_words(input logic [7:0] fc);
    is_words = (fc == FC_RD_REG) || (fc == FC_RD_ANA);
  endfunction

  logic [15:0] start_w, count_w, hi_sel;
  logic [16:0] end_w;
  logic span_ok, bits_ok, words_ok, force_ok;
  logic addr_bcast, addr_mine;
  logic [8:0] nbytes;
  logic tx_free;

  always_comb begin
    start_w = {s_q.q2, s_q.q3};
    count_w = {s_q.q4, s_q.q5};
    end_w = {1'b0, start_w} + {1'b0, count_w};
    unique case (s_q.q1)
      FC_RD_IN: hi_sel = hi_in_i;
      FC_RD_REG: hi_sel = hi_reg_i;
      FC_RD_ANA: hi_sel = hi_ana_i;
      default: hi_sel = hi_out_i;
    endcase
    // Start below the top of the table and the whole span inside it
    span_ok = (start_w < hi_sel) && (end_w <= {1'b0, hi_sel});
    // The count field is wider than a response can hold, so cap it here
    bits_ok = is_bits(s_q.q1) && span_ok && (count_w != 16'h0000) && (count_w <= MAX_POINTS);
    words_ok = is_words(s_q.q1) && span_ok && (count_w >= MIN_WORDS)
               && (count_w <= MAX_WORDS);
    force_ok = (s_q.q1 == FC_FORCE) && (start_w < hi_out_i) && (s_q.q5 == 8'h00)
               && ((s_q.q4 == FORCE_OFF) || (s_q.q4 == FORCE_ON));
    addr_bcast = (s_q.q0 == BCAST_ADDR);
    // Station zero is never ours, so a read sent to it is never answered
    addr_mine = !addr_bcast && (s_q.q0 == station_i);
    if (is_bits(s_q.q1)) begin
      nbytes = 9'((count_w + 16'h0007) >> 3);
    end else begin
      nbytes = 9'({count_w, 1'b0});
    end
  end

  assign tx_free = !s_q.tx.valid || tx_ready_i;

  always_comb begin
    s_d = s_q;
    s_d.rd.req = 1'b0;
    s_d.frc.en = 1'b0;
    s_d.drop = 1'b0;
    if (s_q.tx.valid && tx_ready_i) begin
      s_d.tx.valid = 1'b0;
      s_d.tx.last = 1'b0;
    end
    unique case (s_q.st)
      S_RX: begin
        if (rx_i.valid) begin
          unique case (s_q.cnt)
            3'd0: s_d.q0 = rx_i.data;
            3'd1: s_d.q1 = rx_i.data;
            3'd2: s_d.q2 = rx_i.data;
            3'd3: s_d.q3 = rx_i.data;
            3'd4: s_d.q4 = rx_i.data;
            default: s_d.q5 = rx_i.data;
          endcase
          // A short or long frame is thrown away whole
          if (rx_i.last) begin
            s_d.cnt = 3'd0;
            if (s_q.cnt == 3'(QRY_LEN - 1)) begin
              s_d.st = S_CHECK;
            end else begin
              s_d.drop = 1'b1;
            end
          end else if (s_q.cnt >= 3'(QRY_LEN - 1)) begin
            // Park past the last field so the frame's end sees it as too long
            s_d.cnt = 3'(QRY_LEN);
          end else begin
            s_d.cnt = s_q.cnt + 3'd1;
          end
        end
      end
      S_CHECK: begin
        s_d.st = S_RX;
        s_d.drop = 1'b1;
        if (force_ok && (addr_bcast || addr_mine)) begin
          s_d.drop = 1'b0;
          s_d.frc.en = 1'b1;
          s_d.frc.index = start_w;
          s_d.frc.value = (s_q.q4 == FORCE_ON);
          if (!addr_bcast) begin
            s_d.hdr_pos = 8'd0;
            s_d.st = S_ECHO;
          end
        end else if ((bits_ok || words_ok) && addr_mine) begin
          s_d.drop = 1'b0;
          s_d.idx = start_w;
          s_d.left = count_w;
          s_d.bytes_left = nbytes;
          s_d.hdr_pos = 8'd0;
          s_d.st = S_HDR;
        end
      end
      S_ECHO: begin
        if (tx_free) begin
          s_d.tx.valid = 1'b1;
          s_d.tx.last = (s_q.hdr_pos == 8'd5);
          unique case (s_q.hdr_pos[2:0])
            3'd0: s_d.tx.data = s_q.q0;
            3'd1: s_d.tx.data = s_q.q1;
            3'd2: s_d.tx.data = s_q.q2;
            3'd3: s_d.tx.data = s_q.q3;
            3'd4: s_d.tx.data = s_q.q4;
            default: s_d.tx.data = s_q.q5;
          endcase
          s_d.hdr_pos = s_q.hdr_pos + 8'd1;
          if (s_q.hdr_pos == 8'd5) begin
            s_d.st = S_RX;
          end
        end
      end
      S_HDR: begin
        if (tx_free) begin
          s_d.tx.valid = 1'b1;
          s_d.tx.last = 1'b0;
          unique case (s_q.hdr_pos[1:0])
            2'd0: s_d.tx.data = s_q.q0;
            2'd1: s_d.tx.data = s_q.q1;
            default: s_d.tx.data = nbytes[7:0]; // 256 wraps to zero
          endcase
          s_d.hdr_pos = s_q.hdr_pos + 8'd1;
          if (s_q.hdr_pos == 8'd2) begin
            s_d.acc = 8'h00;
            s_d.bitn = 4'd0;
            s_d.lo_pending = 1'b0;
            s_d.st = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        s_d.rd.req = 1'b1;
        s_d.rd.bits = is_bits(s_q.q1);
        s_d.rd.index = s_q.idx;
        s_d.st = S_WAIT;
      end
      S_WAIT: begin
        if (rd_valid_i) begin
          s_d.left = s_q.left - 16'd1;
          s_d.idx = s_q.idx + 16'd1;
          if (is_bits(s_q.q1)) begin
            s_d.acc[s_q.bitn[2:0]] = rd_data_i[0];
            s_d.bitn = s_q.bitn + 4'd1;
            // Bits above the last point stay at their cleared value
            if (s_q.bitn == 4'd7 || s_q.left == 16'd1) begin
              s_d.st = S_SEND;
            end else begin
              s_d.st = S_FETCH;
            end
          end else begin
            s_d.acc = rd_data_i[15:8];
            s_d.lo_byte = rd_data_i[7:0];
            s_d.lo_pending = 1'b1;
            s_d.st = S_SEND;
          end
        end
      end
      S_SEND: begin
        if (tx_free) begin
          s_d.tx.valid = 1'b1;
          s_d.tx.data = s_q.acc;
          s_d.tx.last = (s_q.bytes_left == 9'd1); // Check bytes follow outside
          s_d.bytes_left = s_q.bytes_left - 9'd1;
          s_d.acc = 8'h00;
          s_d.bitn = 4'd0;
          if (s_q.lo_pending) begin
            s_d.acc = s_q.lo_byte;
            s_d.lo_pending = 1'b0;
          end else if (s_q.bytes_left == 9'd1) begin
            s_d.st = S_RX;
          end else begin
            s_d.st = S_FETCH;
          end
        end
      end
      default: s_d.st = S_RX;
    endcase
    if (rst_i) begin
      s_d = '0;
      s_d.st = S_RX;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign tx_o = s_q.tx;
  assign rd_o = s_q.rd;
  assign force_o = s_q.frc;
  assign drop_o = s_q.drop;
endmodule
`default_nettype wire

//--- dv/rtusd_decoder_assertions.sv
// Checker for the slave query interpreter ports
`timescale 1ns/1ps
`default_nettype none
module rtusd_decoder_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] hi_out_i,
  input wire logic tx_ready_i,
  input wire rtusd_pkg::rtusd_byte_type tx_o,
  input wire rtusd_pkg::rtusd_rd_type rd_o,
  input wire rtusd_pkg::rtusd_force_type force_o,
  input wire logic drop_o
);
  import rtusd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_tx_byte_held: assert property (tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o))
    else $error("tx byte moved");
  chk_tx_ends_clean: assert property (tx_o.valid && tx_ready_i && tx_o.last |=> !tx_o.valid)
    else $error("tx past last");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !tx_o.valid && !rd_o.req && !force_o.en && !drop_o)
    else $error("output after reset");
  chk_fetch_pulse: assert property (rd_o.req |=> !rd_o.req)
    else $error("fetch not a pulse");
  chk_force_pulse: assert property (force_o.en |=> !force_o.en)
    else $error("force not a pulse");
  chk_drop_pulse: assert property (drop_o |=> !drop_o)
    else $error("drop not a pulse");
  chk_force_range: assert property (force_o.en |-> force_o.index < hi_out_i)
    else $error("force out of range");
  chk_drop_silent: assert property (drop_o |-> !tx_o.valid && !force_o.en)
    else $error("drop with action");
endmodule
bind rtusd_decoder rtusd_decoder_assertions rtusd_decoder_assertions_i (.clk_i, .rst_i, .hi_out_i,
  .tx_ready_i, .tx_o, .rd_o, .force_o, .drop_o);
`default_nettype wire

//--- dv/rtusd_table_model.sv
// Table model answering point and word fetches
`timescale 1ns/1ps
`default_nettype none
module rtusd_table_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rtusd_pkg::rtusd_rd_type rd_i,
  input wire logic slow_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o
);
  import rtusd_pkg::*;
  rtusd_rd_type pend_q;
  logic [1:0] wait_q;
  // Idle data flips every cycle so a late sample cannot match
  always_ff @(posedge clk_i) begin
    rd_valid_o <= 1'b0;
    rd_data_o <= ~rd_data_o;
    if (rst_i) begin
      pend_q <= '0;
      rd_data_o <= 16'h0000;
    end else if (rd_i.req) begin
      pend_q <= rd_i;
      wait_q <= slow_i ? 2'h3 : 2'h0;
    end else if (pend_q.req && wait_q == 2'h0) begin
      pend_q.req <= 1'b0;
      rd_valid_o <= 1'b1;
      rd_data_o <= pend_q.bits ? {15'h0000, pend_q.index[0] ^ pend_q.index[3]} : pend_q.index ^ 16'h5a5a;
    end else begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- dv/rtusd_decoder_bench.sv
// Self-checking bench for the slave query interpreter
`timescale 1ns/1ps
`default_nettype none
module rtusd_decoder_bench;
  import rtusd_pkg::*;
  localparam logic [7:0] STN = 8'h11;
  logic clk_i = 0, rst_i = 1, tx_ready_i = 0, slow = 0, rd_valid_i, drop_o;
  logic [15:0] rd_data_i;
  rtusd_byte_type rx_i = '0, tx_o;
  rtusd_rd_type rd_o;
  rtusd_force_type force_o;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int fail_count = 0, n_compared = 0;
  rtusd_decoder rtusd_decoder_i (.clk_i, .rst_i, .station_i(STN), .hi_out_i(16'h0800), .hi_in_i(HI_IN_DEF),
    .hi_reg_i(HI_REG_DEF), .hi_ana_i(HI_ANA_DEF), .rx_i, .tx_ready_i, .tx_o, .rd_o, .rd_valid_i, .rd_data_i,
    .force_o, .drop_o);
  rtusd_table_model rtusd_table_model_i (.clk_i, .rst_i, .rd_i(rd_o), .slow_i(slow), .rd_valid_o(rd_valid_i),
    .rd_data_o(rd_data_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic miss(input string m);
    $display("unexpected at %0t: %s", $time, m);
    fail_count++;
  endtask
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Sink stalls at random while fetches answer promptly or late
  always @(negedge clk_i) begin
    tx_ready_i <= ($urandom % 4) != 0;
    slow <= $urandom % 2;
  end
  always @(posedge clk_i) begin
    if (!rst_i && tx_o.valid === 1'b1 && tx_ready_i) begin
      n_compared++;
      if (exp_q.size() == 0) miss("stray tx byte");
      else begin
        e = exp_q.pop_front();
        if ({tx_o.last, tx_o.data} !== e) miss("tx byte");
      end
    end
  end
  task automatic drain();
    int n;
    for (n = 0; n < 40000 && exp_q.size() != 0; n++) @(posedge clk_i);
    if (n == 40000) begin
      miss("response hang");
      end_of_test();
    end
  endtask
  task automatic query(input logic [7:0] a, f, input logic [15:0] s, c, input bit echo);
    logic [7:0] b[6];
    drain();
    b = '{a, f, s[15:8], s[7:0], c[15:8], c[7:0]};
    for (int i = 0; i < 6; i++) begin
      if (echo) exp_q.push_back({i == 5, b[i]});
      @(negedge clk_i);
      rx_i <= '{1'b1, b[i], i == 5};
    end
    @(negedge clk_i);
    rx_i <= '0;
  endtask
  task automatic wait_flag(input bit frc);
    int n;
    for (n = 0; n < 10; n++) begin
      @(posedge clk_i);
      #1;
      if ((frc ? force_o.en : drop_o) === 1'b1) break;
    end
    n_compared++;
    if (n == 10) miss("no pulse");
  endtask
  // Frames of the wrong length; the first six bytes alone would be a good query
  task automatic frame(input int len);
    logic [7:0] b[7];
    bit seen;
    b = '{STN, FC_RD_REG, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
    drain();
    for (int i = 0; i < len; i++) begin
      @(negedge clk_i);
      rx_i <= '{1'b1, b[i], i == len - 1};
    end
    @(posedge clk_i);
    #1;
    seen = (drop_o === 1'b1);
    @(negedge clk_i);
    rx_i <= '0;
    @(posedge clk_i);
    #1;
    seen = seen || (drop_o === 1'b1);
    n_compared++;
    if (!seen) miss("frame length kept");
  endtask
  task automatic read(input logic [7:0] f, input logic [15:0] s, c);
    int nb;
    logic [7:0] d;
    logic [15:0] w, p;
    // Notes go in only after the query, since query waits for an empty queue
    query(STN, f, s, c, 0);
    nb = (f < FC_RD_REG) ? (c + 7) / 8 : 2 * c;
    exp_q.push_back({1'b0, STN});
    exp_q.push_back({1'b0, f});
    exp_q.push_back({1'b0, nb[7:0]});
    for (int k = 0; k < nb; k++) begin
      w = (s + 16'(k / 2)) ^ 16'h5a5a;
      d = k[0] ? w[7:0] : w[15:8];
      if (f < FC_RD_REG) begin
        for (int j = 0; j < 8; j++) begin
          p = s + 16'(8 * k + j);
          d[j] = (8 * k + j < c) ? (p[0] ^ p[3]) : 1'b0;
        end
      end
      exp_q.push_back({k == nb - 1, d});
    end
  endtask
  task automatic force_pt(input logic [7:0] a, input logic [15:0] idx, input logic [7:0] v);
    query(a, FC_FORCE, idx, {v, 8'h00}, a != BCAST_ADDR);
    wait_flag(1);
    if (force_o.index !== idx || force_o.value !== (v == FORCE_ON)) miss("force target");
  endtask
  initial begin
    void'($urandom(32'h1346));
    repeat (5) @(negedge clk_i);
    rst_i <= 1'b0;
    read(FC_RD_OUT, 16'h0003, 16'h000a);
    read(FC_RD_IN, 16'h00f8, 16'h0008);
    read(FC_RD_OUT, 16'h0000, MAX_POINTS);
    read(FC_RD_REG, 16'h0000, MAX_WORDS);
    read(FC_RD_ANA, HI_ANA_DEF - 16'h0001, MIN_WORDS);
    for (int i = 0; i < 3; i++) read(FC_RD_REG, 16'($urandom % 896), 16'($urandom % 125 + 1));
    query(STN, FC_RD_REG, 16'h0000, MAX_WORDS + 16'h0001, 0);
    wait_flag(0);
    query(STN, FC_RD_IN, 16'h00f9, 16'h0008, 0);
    wait_flag(0);
    query(BCAST_ADDR, FC_RD_ANA, 16'h0000, MIN_WORDS, 0);
    wait_flag(0);
    query(STN + 8'h01, FC_RD_OUT, 16'h0000, 16'h0001, 0);
    wait_flag(0);
    frame(5);
    frame(7);
    force_pt(STN, 16'h07ff, FORCE_ON);
    force_pt(STN, 16'h0007, FORCE_OFF);
    force_pt(BCAST_ADDR, 16'h0001, FORCE_ON);
    query(STN, FC_FORCE, 16'h0002, 16'h1200, 0);
    wait_flag(0);
    query(STN, FC_FORCE, 16'h0800, 16'hff00, 0);
    wait_flag(0);
    drain();
    end_of_test();
  end
endmodule
`default_nettype wire
